// ### verilog/cbv_pkg.sv
`default_nettype none
package cbv_pkg;
    // Serial port framing: 8 address bits then 24 data bits, least significant first.
    localparam int SER_ADDR_W = 8;
    localparam int SER_DATA_W = 24;
    localparam int SER_FRAME_W = 32;
    // Register addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] ADDR_RETIME = 8'h03;
    localparam logic [7:0] ADDR_HCTRL = 8'h0A;
    localparam logic [7:0] ADDR_HPOS = 8'h10;
    localparam logic [7:0] ADDR_EXTLEN = 8'h11;
    localparam logic [7:0] ADDR_CHG_A = 8'h12;
    localparam logic [7:0] ADDR_CHG_B = 8'h13;
    localparam logic [7:0] ADDR_PTR = 8'h14;
    localparam logic [7:0] ADDR_SEL = 8'h15;
    localparam logic [7:0] ADDR_CLAMP = 8'h16;
    // Pattern store: address bits [7:5] equal this, [4:3] pattern, [2:0] word.
    localparam logic [2:0] PAT_PAGE = 3'h1;
    localparam logic [2:0] PW_SPACING = 3'h0;
    localparam logic [2:0] PW_REPEAT = 3'h1;
    // Words 4..7 hold the two edges of outputs 1..4; bit 2 marks them.
    localparam int PW_EDGE_BIT = 2;
    // Field positions.
    localparam int B_MASK_POL = 0;
    localparam int B_SHUT_EN = 1;
    localparam int B_SLAVE = 2;
    localparam int B_RETIME = 0;
    localparam int B_PULSE_CNT = 0;
    localparam int B_EXTEND = 1;
    localparam int F_START_LSB = 9;
    localparam int F_EDGE2_LSB = 9;
    localparam int F_SEL_W = 2;
    localparam int F_PTR_W = 3;
    localparam int F_CLAMP_OFF_LSB = 10;
    // Widths.
    localparam int HPOS_W = 10;
    localparam int EXT_W = 9;
    localparam int VPOS_W = 9;
    localparam int LINE_W = 8;
    localparam int REP_W = 8;
    localparam int NREG = 5;
    localparam int NPAT = 4;
    localparam int NVOUT = 4;
    // Second pulse in selective blanking follows the first by this many pixels.
    localparam logic [9:0] PULSE_GAP = 10'h002;
    localparam logic [23:0] RESET_VALUE = 24'h00_0000;

    typedef struct packed {
        logic [VPOS_W-1:0] spacing;
        logic [NVOUT-1:0] start;
        logic [REP_W-1:0] repeat_cnt;
        logic [NVOUT-1:0][VPOS_W-1:0] edge_one;
        logic [NVOUT-1:0][VPOS_W-1:0] edge_two;
    } cbv_pat_t;

    typedef enum logic [1:0] {
        H_ACTIVE = 2'b00,
        H_EXTEND = 2'b01,
        H_BLANK = 2'b11
    } cbv_hstate_t;
endpackage
`default_nettype wire

// ### verilog/cbv_pat_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cbv_pat_if;
    import cbv_pkg::*;
    logic wr_en;
    logic [1:0] wr_pat;
    logic [2:0] wr_word;
    logic [SER_DATA_W-1:0] wr_data;
    logic [1:0] rd_pat;
    cbv_pat_t rd_rec;
    modport store(input wr_en, input wr_pat, input wr_word, input wr_data, input rd_pat,
                  output rd_rec);
    modport user(output wr_en, output wr_pat, output wr_word, output wr_data, output rd_pat,
                 input rd_rec);
endinterface
`default_nettype wire

// ### verilog/cbv_pattern_store.sv
`timescale 1ns/100ps
`default_nettype none
module cbv_pattern_store import cbv_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    cbv_pat_if.store pif
);
    cbv_pat_t mem_q [NPAT];
    cbv_pat_t rd_q;

    for (genvar p = 0; p < NPAT; p++) begin : g_pat
        wire logic hit = pif.wr_en && (pif.wr_pat == 2'(p));
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                mem_q[p] <= '0;
            end else if (hit && pif.wr_word[PW_EDGE_BIT]) begin
                mem_q[p].edge_one[pif.wr_word[1:0]] <= pif.wr_data[VPOS_W-1:0];
                mem_q[p].edge_two[pif.wr_word[1:0]] <= pif.wr_data[F_EDGE2_LSB +: VPOS_W];
            end else if (hit && pif.wr_word == PW_SPACING) begin
                mem_q[p].spacing <= pif.wr_data[VPOS_W-1:0];
                mem_q[p].start <= pif.wr_data[F_START_LSB +: NVOUT];
            end else if (hit && pif.wr_word == PW_REPEAT) begin
                mem_q[p].repeat_cnt <= pif.wr_data[REP_W-1:0];
            end
        end
    end

    // The record of the pattern in use is registered, so it lags the select by one clock.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem_q[pif.rd_pat];
        end
    end
    assign pif.rd_rec = rd_q;
endmodule // cbv_pattern_store
`default_nettype wire

// ### verilog/cbv_timing.sv
// Overview of operation
// - Pulse count 1 gives two phase-A pulses during blanking at the programmed position.
// - Extended blanking: 9-bit counter suspends the line pixel counter for the length.
// - Mask polarity sets phase A level in blanking: 0 low, 1 high.
// - Phase B is always the inverse of phase A, blanking included.
// - Pulse count 0 gives no horizontal clock in blanking; 1 gives pulses.
// - Retime bit 1 registers the blanking signal on the clock; 0 uses it directly.
// - A 10-bit position sets where phase A pulses away from its mask level during blanking.
// - Extended blanking shifts horizontal edges only, never vertical or clamp timing.
// - In slave mode the shared pin is a gate input masking vertical outputs and clamp.
// - Shutter enable 0: gate latched at line sync fall masks while high.
// - Shutter enable 1: latched gate masks only while the shutter signal is high.
// - Four programmable vertical patterns, each covering all four vertical outputs.
// - Up to five regions, stepped through one after another over the field.
// - Per pattern, a spacing between repetitions and a start level per output.
// - Each output toggles at two programmed positions measured from pattern start.
// - Repeat count sets pulses per line; 0 holds the start level.
// - Region pointer picks a select register whose value picks the pattern.
// - 8-bit change lines bound regions; first fixed at line 0, four programmable.
// - Pulse count 0: both phases blanked while line sync low, position unused.
// - The first region always begins at the frame sync falling edge.
//
`timescale 1ns/100ps
`default_nettype none
module cbv_timing import cbv_pkg::*; (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic line_sync,
    input wire logic frame_sync,
    input wire logic sync_gate_pin,
    input wire logic mech_shutter_signal,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_load_n,
    output logic horiz_clock_phase_a,
    output logic horiz_clock_phase_b,
    output logic vert_transfer_out_1,
    output logic vert_transfer_out_2,
    output logic vert_transfer_out_3,
    output logic vert_transfer_out_4,
    output logic black_clamp_pulse
);
    ////////////////////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pin order: 0 line sync, 1 frame sync, 2 gate, 3 shutter, 4 serial clk, 5 data, 6 load.
    localparam int NPIN = 7;
    wire logic [NPIN-1:0] pin_raw = {ser_load_n, ser_data, ser_clk, mech_shutter_signal,
                                     sync_gate_pin, frame_sync, line_sync};
    logic [NPIN-1:0] meta_q;
    logic [NPIN-1:0] pin_q;
    logic [NPIN-1:0] pin_prev_q;
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q[i] <= 1'b1;
                pin_q[i] <= 1'b1;
                pin_prev_q[i] <= 1'b1;
            end else begin
                meta_q[i] <= pin_raw[i];
                pin_q[i] <= meta_q[i];
                pin_prev_q[i] <= pin_q[i];
            end
        end
    end
    wire logic line_fall = pin_prev_q[0] && !pin_q[0];
    wire logic line_rise = !pin_prev_q[0] && pin_q[0];
    wire logic frame_fall = pin_prev_q[1] && !pin_q[1];
    wire logic ser_clk_rise = !pin_prev_q[4] && pin_q[4];
    wire logic ser_load_rise = !pin_prev_q[6] && pin_q[6];

    ////////////////////////////////////////////////////////////////////////////////////////
    // Write-only three-wire port; a frame is committed when the load line returns high.
    logic [SER_FRAME_W-1:0] ser_shift_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_shift_q <= '0;
        end else if (ser_clk_rise && !pin_q[6]) begin
            ser_shift_q <= {pin_q[5], ser_shift_q[SER_FRAME_W-1:1]};
        end
    end
    wire logic [7:0] wr_addr = ser_shift_q[SER_ADDR_W-1:0];
    wire logic [SER_DATA_W-1:0] wr_data = ser_shift_q[SER_FRAME_W-1:SER_ADDR_W];

    function automatic logic wr_hit(input logic go, input logic [7:0] a, input logic [7:0] r);
        return go && (a == r);
    endfunction

    logic [SER_DATA_W-1:0] ctrl_q, retime_q, hctrl_q, hpos_q, extlen_q;
    logic [SER_DATA_W-1:0] chg_a_q, chg_b_q, ptr_q, sel_q, clamp_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {ctrl_q, retime_q, hctrl_q, hpos_q, extlen_q} <= {5{RESET_VALUE}};
            {chg_a_q, chg_b_q, ptr_q, sel_q, clamp_q} <= {5{RESET_VALUE}};
        end else begin
            if (wr_hit(ser_load_rise, wr_addr, ADDR_CTRL)) ctrl_q <= wr_data;
            if (wr_hit(ser_load_rise, wr_addr, ADDR_RETIME)) retime_q <= wr_data;
            if (wr_hit(ser_load_rise, wr_addr, ADDR_HCTRL)) hctrl_q <= wr_data;
            if (wr_hit(ser_load_rise, wr_addr, ADDR_HPOS)) hpos_q <= wr_data;
            if (wr_hit(ser_load_rise, wr_addr, ADDR_EXTLEN)) extlen_q <= wr_data;
            if (wr_hit(ser_load_rise, wr_addr, ADDR_CHG_A)) chg_a_q <= wr_data;
            if (wr_hit(ser_load_rise, wr_addr, ADDR_CHG_B)) chg_b_q <= wr_data;
            if (wr_hit(ser_load_rise, wr_addr, ADDR_PTR)) ptr_q <= wr_data;
            if (wr_hit(ser_load_rise, wr_addr, ADDR_SEL)) sel_q <= wr_data;
            if (wr_hit(ser_load_rise, wr_addr, ADDR_CLAMP)) clamp_q <= wr_data;
        end
    end
    wire logic blank_mask_polarity = ctrl_q[B_MASK_POL];
    wire logic shutter_gate_enable = ctrl_q[B_SHUT_EN];
    wire logic slave_mode = ctrl_q[B_SLAVE];
    wire logic blank_retime_enable = retime_q[B_RETIME];
    wire logic blank_pulse_count = hctrl_q[B_PULSE_CNT];
    wire logic blank_extend_enable = hctrl_q[B_EXTEND];
    wire logic [HPOS_W-1:0] blank_pulse_position = hpos_q[HPOS_W-1:0];
    wire logic [EXT_W-1:0] blank_extend_length = extlen_q[EXT_W-1:0];

    cbv_pat_if pif();
    assign pif.wr_en = ser_load_rise && (wr_addr[7:5] == PAT_PAGE);
    assign pif.wr_pat = wr_addr[4:3];
    assign pif.wr_word = wr_addr[2:0];
    assign pif.wr_data = wr_data;
    cbv_pattern_store u_store (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pif(pif)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Horizontal blanking. Extension holds the line pixel counter before blanking is shown.
    cbv_hstate_t hstate_q, hstate_d;
    logic [EXT_W-1:0] blank_extend_counter;
    logic [HPOS_W-1:0] line_pixel_counter;
    wire logic ext_done = (blank_extend_counter + 9'h001 >= blank_extend_length);
    always_comb begin
        hstate_d = hstate_q;
        unique case (hstate_q)
            H_ACTIVE: if (line_fall) hstate_d = blank_extend_enable ? H_EXTEND : H_BLANK;
            H_EXTEND: if (ext_done) hstate_d = H_BLANK;
            H_BLANK: if (pin_q[0]) hstate_d = H_ACTIVE;
            default: hstate_d = H_ACTIVE;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hstate_q <= H_ACTIVE;
            blank_extend_counter <= '0;
            line_pixel_counter <= '0;
        end else begin
            hstate_q <= hstate_d;
            blank_extend_counter <= (hstate_q == H_EXTEND) ? blank_extend_counter + 9'h001 : '0;
            if (line_fall) begin
                line_pixel_counter <= '0;
            end else if (hstate_q != H_EXTEND) begin
                line_pixel_counter <= line_pixel_counter + 10'h001;
            end
        end
    end

    // Retiming adds a clock of latency but removes decode glitches from the blank edge.
    wire logic blank_raw = (hstate_q == H_BLANK);
    logic blank_rt_q, h_toggle_q, h1_q, h2_q;
    wire logic blank_sel = blank_retime_enable ? blank_rt_q : blank_raw;
    wire logic pulse_hit = (line_pixel_counter == blank_pulse_position) ||
                           (line_pixel_counter == blank_pulse_position + PULSE_GAP);
    wire logic blank_level = (blank_pulse_count && pulse_hit) ? !blank_mask_polarity
                                                              : blank_mask_polarity;
    wire logic h1_d = blank_sel ? blank_level : h_toggle_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blank_rt_q <= 1'b0;
            h_toggle_q <= 1'b0;
            h1_q <= 1'b0;
            h2_q <= 1'b1;
        end else begin
            blank_rt_q <= blank_raw;
            h_toggle_q <= !h_toggle_q;
            h1_q <= h1_d;
            h2_q <= !h1_d;
        end
    end
    assign horiz_clock_phase_a = h1_q;
    assign horiz_clock_phase_b = h2_q;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Vertical side runs from its own counters, untouched by the blank extension.
    logic [LINE_W-1:0] line_q;
    logic [HPOS_W-1:0] pix_q;
    logic gate_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_q <= '0;
            pix_q <= '0;
            gate_q <= 1'b0;
        end else begin
            if (frame_fall) begin
                line_q <= '0;
            end else if (line_fall) begin
                line_q <= line_q + 8'h01;
            end
            pix_q <= line_fall ? '0 : pix_q + 10'h001;
            if (line_fall) gate_q <= pin_q[2];
        end
    end

    function automatic logic [2:0] region_of(input logic [LINE_W-1:0] ln,
                                             input logic [4*LINE_W-1:0] chg);
        logic [2:0] r;
        r = 3'h0;
        // A change line of zero counts as unused, so the first region always owns line 0.
        for (int k = 0; k < NREG - 1; k++) begin
            if ((chg[k*LINE_W +: LINE_W] != '0) && (ln >= chg[k*LINE_W +: LINE_W])) r = 3'(k + 1);
        end
        return r;
    endfunction

    wire logic [4*LINE_W-1:0] chg_all = {chg_b_q[15:0], chg_a_q[15:0]};
    wire logic [2:0] region = region_of(line_q, chg_all);
    wire logic [F_PTR_W-1:0] cur_ptr = ptr_q[region*F_PTR_W +: F_PTR_W];
    wire logic [2:0] sel_idx = (cur_ptr < 3'(NREG)) ? cur_ptr : 3'h0;
    assign pif.rd_pat = sel_q[sel_idx*F_SEL_W +: F_SEL_W];
    wire cbv_pat_t pr = pif.rd_rec;

    logic [VPOS_W-1:0] vphase_q;
    logic [REP_W-1:0] rep_q;
    logic [NVOUT-1:0] vlev_q, vout_q;
    wire logic [NVOUT-1:0] vlev_d;
    wire logic reps_left = (rep_q < pr.repeat_cnt);
    wire logic rep_wrap = (vphase_q + 9'h001 >= pr.spacing);
    for (genvar v = 0; v < NVOUT; v++) begin : g_vout
        wire logic tog = reps_left && ((vphase_q == pr.edge_one[v]) ||
                                       (vphase_q == pr.edge_two[v]));
        assign vlev_d[v] = line_fall ? pr.start[v] : (vlev_q[v] ^ tog);
    end
    wire logic shut_block = shutter_gate_enable && !pin_q[3];
    wire logic vmask = slave_mode && gate_q && !shut_block;
    wire logic clamp_win = (pix_q >= clamp_q[HPOS_W-1:0]) &&
                           (pix_q < clamp_q[F_CLAMP_OFF_LSB +: HPOS_W]);
    logic clamp_q_out;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vphase_q <= '0;
            rep_q <= '0;
            vlev_q <= '0;
            vout_q <= '0;
            clamp_q_out <= 1'b0;
        end else begin
            if (line_fall) begin
                vphase_q <= '0;
                rep_q <= '0;
            end else if (reps_left) begin
                vphase_q <= rep_wrap ? '0 : vphase_q + 9'h001;
                if (rep_wrap) rep_q <= rep_q + 8'h01;
            end
            vlev_q <= vlev_d;
            vout_q <= vmask ? '0 : vlev_d;
            clamp_q_out <= clamp_win && !vmask;
        end
    end
    assign {vert_transfer_out_4, vert_transfer_out_3, vert_transfer_out_2,
            vert_transfer_out_1} = vout_q;
    assign black_clamp_pulse = clamp_q_out;

    ////////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence ext_begin_s;
        line_fall && blank_extend_enable && hstate_q == H_ACTIVE;
    endsequence
    phase_inverse_a: assert property (h2_q == !h1_q)
        else $error("phase B not inverse of phase A");
    blank_level_a: assert property (blank_sel && !blank_pulse_count
        |=> h1_q == $past(blank_mask_polarity))
        else $error("blank level wrong");
    blank_pulse_a: assert property (blank_sel && blank_pulse_count && pulse_hit
        |=> h1_q != $past(blank_mask_polarity))
        else $error("blank pulse missing");
    ext_suspend_a: assert property (ext_begin_s ##1 hstate_q == H_EXTEND
        |=> $stable(line_pixel_counter))
        else $error("pixel counter ran while suspended");
    ext_resume_a: assert property (hstate_q == H_EXTEND && ext_done
        |=> hstate_q == H_BLANK ##1 line_pixel_counter != $past(line_pixel_counter))
        else $error("extension did not end");
    gate_mask_a: assert property (vmask |=> vout_q == '0 && !black_clamp_pulse)
        else $error("gate did not mask");
    shutter_ignore_a: assert property (shut_block |-> !vmask)
        else $error("gate masked while shutter low");
    repeat_zero_a: assert property (pr.repeat_cnt == '0 && !line_fall
        |=> vlev_q == $past(vlev_q))
        else $error("output moved with zero repeat");
    frame_region_a: assert property (frame_fall |=> region == 3'h0)
        else $error("frame start not in first region");
    line_start_a: assert property (line_fall |=> vlev_q == $past(pr.start))
        else $error("start level not loaded");
    retime_delay_a: assert property (blank_retime_enable |-> blank_sel == $past(blank_raw))
        else $error("retimed blank not one clock late");
endmodule // cbv_timing
`default_nettype wire

// ### verification/cbv_ccd_model.sv
`timescale 1ns/100ps
`default_nettype none
// Sensor side: counts phase A rises and vertical output 1 edges, and notes any
// cycle where the two horizontal phases are not complementary.
module cbv_ccd_model (
    input wire logic core_clk,
    input wire logic clr,
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic v1,
    output logic [7:0] a_rises,
    output logic [7:0] v1_edges,
    output logic b_bad
);
    logic a_q;
    logic v1_q;
    always_ff @(posedge core_clk) begin
        a_q <= phase_a;
        v1_q <= v1;
        if (clr) begin
            a_rises <= 8'h00;
            v1_edges <= 8'h00;
            b_bad <= 1'b0;
        end else begin
            if (phase_a && !a_q) a_rises <= a_rises + 8'h01;
            if (v1 !== v1_q) v1_edges <= v1_edges + 8'h01;
            if (phase_b !== ~phase_a) b_bad <= 1'b1;
        end
    end
endmodule // cbv_ccd_model
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import cbv_pkg::*;;
    logic core_clk = 1'b0, rstn = 1'b0, line_sync = 1'b1, frame_sync = 1'b1;
    logic gate = 1'b0, shut = 1'b0, ser_clk = 1'b0, ser_data = 1'b0, ser_load_n = 1'b1;
    logic ha, hb, v1, v2, v3, v4, clamp, clr = 1'b1, b_bad;
    logic [7:0] a_rises, v1_edges;
    int err_total = 0, compares = 0;
    always #20 core_clk = ~core_clk;
    cbv_timing u_dut (.core_clk(core_clk), .rstn(rstn), .line_sync(line_sync),
        .frame_sync(frame_sync), .sync_gate_pin(gate), .mech_shutter_signal(shut),
        .ser_clk(ser_clk), .ser_data(ser_data), .ser_load_n(ser_load_n),
        .horiz_clock_phase_a(ha), .horiz_clock_phase_b(hb), .vert_transfer_out_1(v1),
        .vert_transfer_out_2(v2), .vert_transfer_out_3(v3), .vert_transfer_out_4(v4),
        .black_clamp_pulse(clamp));
    cbv_ccd_model u_ccd (.core_clk(core_clk), .clr(clr), .phase_a(ha), .phase_b(hb),
        .v1(v1), .a_rises(a_rises), .v1_edges(v1_edges), .b_bad(b_bad));
    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Frame goes out address first, least significant bit first.
    task automatic wr(input logic [7:0] addr, input logic [23:0] data);
        logic [31:0] frame;
        frame = {data, addr};
        cyc(1);
        ser_load_n <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            ser_data <= frame[i];
            ser_clk <= 1'b0;
            cyc(4);
            ser_clk <= 1'b1;
            cyc(4);
        end
        ser_clk <= 1'b0;
        ser_load_n <= 1'b1;
        cyc(9);
    endtask
    // One line: clears the sensor counters shortly after the line starts. The phase A
    // rise count is taken before the line ends, since active toggling resumes after it.
    task automatic line(input int clr_at, output logic [7:0] rises);
        line_sync <= 1'b0;
        cyc(clr_at);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        cyc(44 - clr_at);
        rises = a_rises;
        line_sync <= 1'b1;
        cyc(60);
    endtask
    // Cycles from the line fall until phase A stops toggling; even spacing keeps parity.
    task automatic blank_lat(output int k);
        logic prev;
        line_sync <= 1'b0;
        cyc(1);
        prev = ha;
        for (k = 1; k < 60 && !(k > 1 && ha === prev); k++) begin
            prev = ha;
            cyc(1);
        end
        if (k >= 60) begin
            chk(16'h0000, 16'h0001);
            results();
        end
        cyc(70 - k);
        line_sync <= 1'b1;
        cyc(40);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_normal();
        logic [7:0] r;
        wr(ADDR_RETIME, 24'h00_0001);
        wr(ADDR_CTRL, 24'h00_0001);
        line(8, r);
        chk(r, 16'h0000);
        line_sync <= 1'b0;
        cyc(20);
        chk(ha, 16'h0001);
        line_sync <= 1'b1;
        cyc(20);
        chk(b_bad, 16'h0000);
    endtask
    task automatic t_select();
        logic [7:0] r;
        wr(ADDR_CTRL, 24'h00_0000);
        wr(ADDR_HPOS, 24'h00_0014);
        wr(ADDR_HCTRL, 24'h00_0001);
        line(8, r);
        chk(r, 16'h0002);
        chk(b_bad, 16'h0000);
    endtask
    task automatic t_extend();
        int k0;
        int k1;
        wr(ADDR_CTRL, 24'h00_0001);
        wr(ADDR_EXTLEN, 24'h00_0008);
        wr(ADDR_HCTRL, 24'h00_0000);
        blank_lat(k0);
        wr(ADDR_HCTRL, 24'h00_0002);
        blank_lat(k1);
        chk(16'(k1 - k0), 16'h0008);
        wr(ADDR_HCTRL, 24'h00_0000);
    endtask
    task automatic t_vert();
        logic [7:0] r;
        wr(8'h20, 24'h00_0014);
        wr(8'h21, 24'h00_0002);
        wr(8'h24, 24'h00_1003);
        line(1, r);
        chk(v1_edges, 16'h0004);
        chk(v1, 16'h0000);
        wr(8'h21, 24'h00_0000);
        wr(8'h20, 24'h00_1E14);
        line(1, r);
        chk(v1_edges, 16'h0001);
        chk({v4, v3, v2, v1}, 16'h000F);
        // Lines from 2 on fall in region 1, which points at select 1 and so at pattern 1.
        wr(ADDR_CHG_A, 24'h00_0002);
        wr(ADDR_PTR, 24'h00_0008);
        wr(ADDR_SEL, 24'h00_0004);
        line(1, r);
        chk({v1_edges, v4, v3, v2, v1}, 16'h0010);
        frame_sync <= 1'b0;
        cyc(8);
        frame_sync <= 1'b1;
        line(1, r);
        chk({v1_edges, v4, v3, v2, v1}, 16'h001F);
        wr(ADDR_CHG_A, 24'h00_0000);
    endtask
    task automatic t_gate();
        logic [7:0] r;
        wr(ADDR_CLAMP, 24'h0F_FC00);
        wr(ADDR_CTRL, 24'h00_0004);
        gate <= 1'b1;
        line(8, r);
        chk({v4, v3, v2, v1, clamp}, 16'h0000);
        wr(ADDR_CTRL, 24'h00_0006);
        line(8, r);
        chk({v4, v3, v2, v1, clamp}, 16'h001F);
        shut <= 1'b1;
        line(8, r);
        chk({v4, v3, v2, v1, clamp}, 16'h0000);
        gate <= 1'b0;
        line(8, r);
        chk({v4, v3, v2, v1, clamp}, 16'h001F);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(16);
        chk({ha, hb, v1, clamp}, 16'h0004);
        rstn <= 1'b1;
        cyc(10);
        clr <= 1'b0;
        t_normal();
        t_select();
        t_extend();
        t_vert();
        t_gate();
        results();
    end
endmodule // tb
`default_nettype wire
